/* oscsel_div.sv */
`timescale 1ns/1ps
// ****************************************************************
// Shared constants and types
// ****************************************************************
package oscsel_pkg;

	localparam int unsigned CORE_CLK_KHZ = 40000;
	localparam int unsigned N_FREQ       = 21;
	localparam int unsigned IDX_W        = 5;
	localparam int unsigned KHZ_W        = 18;
	localparam int unsigned PHASE_W      = 32;
	localparam int unsigned PHASE_MSB    = PHASE_W - 1;
	localparam int unsigned DIV_W        = 8;

	localparam logic [IDX_W-1:0]   DEFAULT_IDX  = 5'h00;
	localparam logic [IDX_W-1:0]   LAST_IDX     = 5'h14;
	localparam logic [KHZ_W-1:0]   DEFAULT_KHZ  = 18'h0_0820;
	localparam logic [PHASE_W-1:0] PHASE_RST    = 32'h0000_0000;
	localparam logic [DIV_W-1:0]   DIV_CNT_RST  = 8'h00;

	typedef enum logic [0:0]
	{
		ST_PWRUP = 1'b0,
		ST_CONF  = 1'b1
	} oscsel_state_t;

	typedef struct packed
	{
		oscsel_state_t      st;
		logic [IDX_W-1:0]   pend_idx;
		logic               pend_vld;
		logic [IDX_W-1:0]   idx;
		logic [KHZ_W-1:0]   khz;
		logic [PHASE_W-1:0] phase;
		logic               run;
		logic               osc;
		logic               gclk;
		logic               pll;
	} oscsel_top_t;

	typedef struct packed
	{
		logic [DIV_W-1:0] cnt;
		logic             prev;
		logic             dclk;
	} oscsel_div_t;

endpackage : oscsel_pkg

// ****************************************************************
// Divider of the oscillator output
// ****************************************************************
module oscsel_div
	import oscsel_pkg::*;
#(
	parameter int unsigned W = DIV_W
)
(
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Oscillator side
	input  wire logic         osc_run,
	input  wire logic         osc_level,
	input  wire logic [W-1:0] div_ratio,
	// Divided output
	output logic              div_clk
);

	oscsel_div_t s_r;
	oscsel_div_t s_nxt;

	always_comb
	begin
		s_nxt      = s_r;
		s_nxt.prev = osc_level;
		if (!osc_run)
		begin
			s_nxt.cnt  = DIV_CNT_RST;
			s_nxt.dclk = 1'b0;
		end
		else if (osc_level && !s_r.prev)
		begin
			// Toggle every div_ratio+1 rising edges
			if (s_r.cnt >= div_ratio)
			begin
				s_nxt.cnt  = DIV_CNT_RST;
				s_nxt.dclk = ~s_r.dclk;
			end
			else
			begin
				s_nxt.cnt = s_r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_r <= '{cnt: DIV_CNT_RST, prev: 1'b0, dclk: 1'b0};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign div_clk = s_r.dclk;

endmodule : oscsel_div

/* oscsel_top.sv */
`timescale 1ns/1ps
module oscsel_top
	import oscsel_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst,
	// Enable controls
	input  wire logic             cfg_osc_en,
	input  wire logic             user_osc_en,
	// Configuration stream
	input  wire logic             cfg_freq_wr,
	input  wire logic [IDX_W-1:0] cfg_freq_sel,
	input  wire logic             cfg_clk_bits_rcvd,
	input  wire logic             cfg_restart,
	// Routing and division
	input  wire logic             route_to_pll,
	input  wire logic [DIV_W-1:0] div_ratio,
	// Outputs
	output logic                  osc_out,
	output logic                  gclk_src,
	output logic                  pll_ref,
	output logic                  div_clk,
	output logic                  osc_running,
	output logic                  configured,
	output logic [IDX_W-1:0]      mclk_idx,
	output logic [KHZ_W-1:0]      mclk_khz
);

	// ****************************************************************
	// Frequency table
	// ****************************************************************
	function automatic logic [KHZ_W-1:0] freq_khz(input logic [IDX_W-1:0] i);
		logic [KHZ_W-1:0] k;
		k = DEFAULT_KHZ;
		unique case (i)
			5'h00: k = 18'h0_0820;
			5'h01: k = 18'h0_099C;
			5'h02: k = 18'h0_0C62;
			5'h03: k = 18'h0_10C2;
			5'h04: k = 18'h0_15A4;
			5'h05: k = 18'h0_1B58;
			5'h06: k = 18'h0_2076;
			5'h07: k = 18'h0_23D2;
			5'h08: k = 18'h0_27F6;
			5'h09: k = 18'h0_33F4;
			5'h0A: k = 18'h0_39BC;
			5'h0B: k = 18'h0_4FEC;
			5'h0C: k = 18'h0_67E8;
			5'h0D: k = 18'h0_7378;
			5'h0E: k = 18'h0_81E2;
			5'h0F: k = 18'h0_9470;
			5'h10: k = 18'h0_AD2A;
			5'h11: k = 18'h0_CFD0;
			5'h12: k = 18'h1_03C4;
			5'h13: k = 18'h1_5A5E;
			5'h14: k = 18'h2_0788;
			default: k = DEFAULT_KHZ;
		endcase
		return k;
	endfunction : freq_khz

	// Phase step per core cycle, wraps modulo the accumulator
	function automatic logic [PHASE_W-1:0] phase_inc(input logic [IDX_W-1:0] i);
		logic [63:0] p;
		p = ({46'h0, freq_khz(i)} << PHASE_W) / 64'(CORE_CLK_KHZ);
		return p[PHASE_W-1:0];
	endfunction : phase_inc

	function automatic logic idx_legal(input logic [IDX_W-1:0] i);
		logic ok;
		ok = (i <= LAST_IDX);
		return ok;
	endfunction : idx_legal

	// ****************************************************************
	// State update
	// ****************************************************************
	oscsel_top_t s_r;
	oscsel_top_t s_nxt;

	always_comb
	begin
		logic             run;
		logic             pv;
		logic [IDX_W-1:0] pi;
		run = 1'b0;
		pv  = 1'b0;
		pi  = DEFAULT_IDX;
		s_nxt = s_r;

		// ****************************************************************
		// Pending selection, illegal codes ignored
		// ****************************************************************
		pv = s_r.pend_vld;
		pi = s_r.pend_idx;
		if (cfg_freq_wr && idx_legal(cfg_freq_sel))
		begin
			pv = 1'b1;
			pi = cfg_freq_sel;
		end
		s_nxt.pend_vld = pv;
		s_nxt.pend_idx = pi;

		// ****************************************************************
		// Selection state machine
		// ****************************************************************
		unique case (s_r.st)
			ST_PWRUP:
			begin
				s_nxt.idx = DEFAULT_IDX;
				if (cfg_clk_bits_rcvd)
				begin
					s_nxt.st       = ST_CONF;
					s_nxt.idx      = pv ? pi : DEFAULT_IDX;
					s_nxt.pend_vld = 1'b0;
					s_nxt.pend_idx = DEFAULT_IDX;
				end
			end
			ST_CONF:
			begin
				if (cfg_restart)
				begin
					s_nxt.st       = ST_PWRUP;
					s_nxt.idx      = DEFAULT_IDX;
					// A selection written with the restart outlives it
					s_nxt.pend_vld = cfg_freq_wr && idx_legal(cfg_freq_sel);
					s_nxt.pend_idx = s_nxt.pend_vld ? cfg_freq_sel : DEFAULT_IDX;
				end
			end
		endcase
		s_nxt.khz = freq_khz(s_nxt.idx);

		// ****************************************************************
		// Oscillator model
		// ****************************************************************
		run       = cfg_osc_en && user_osc_en;
		s_nxt.run = run;
		if (run)
		begin
			s_nxt.phase = s_r.phase + phase_inc(s_r.idx);
			s_nxt.osc   = s_r.phase[PHASE_MSB];
		end
		else
		begin
			s_nxt.phase = PHASE_RST;
			s_nxt.osc   = 1'b0;
		end

		// ****************************************************************
		// Output routing
		// ****************************************************************
		if (route_to_pll)
		begin
			s_nxt.gclk = 1'b0;
			s_nxt.pll  = s_r.osc;
		end
		else
		begin
			s_nxt.gclk = s_r.osc;
			s_nxt.pll  = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_r <= '{
				st:       ST_PWRUP,
				pend_idx: DEFAULT_IDX,
				pend_vld: 1'b0,
				idx:      DEFAULT_IDX,
				khz:      DEFAULT_KHZ,
				phase:    PHASE_RST,
				run:      1'b0,
				osc:      1'b0,
				gclk:     1'b0,
				pll:      1'b0
			};
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Divider
	// ****************************************************************
	oscsel_div #(
		.W (DIV_W)
	) u_oscsel_div (
		.core_clk  (core_clk),
		.rst       (rst),
		.osc_run   (s_r.run),
		.osc_level (s_r.osc),
		.div_ratio (div_ratio),
		.div_clk   (div_clk)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign osc_out     = s_r.osc;
	assign gclk_src    = s_r.gclk;
	assign pll_ref     = s_r.pll;
	assign osc_running = s_r.run;
	assign configured  = (s_r.st == ST_CONF);
	assign mclk_idx    = s_r.idx;
	assign mclk_khz    = s_r.khz;

endmodule : oscsel_top

/* oscsel_top_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// Port checks of the top module
// ****************************************************************
module oscsel_top_chk
	import oscsel_pkg::*;
(
	// Inputs
	input wire logic             core_clk,
	input wire logic             rst,
	input wire logic             cfg_osc_en,
	input wire logic             user_osc_en,
	input wire logic             cfg_clk_bits_rcvd,
	input wire logic             route_to_pll,
	// Outputs
	input wire logic             osc_out,
	input wire logic             gclk_src,
	input wire logic             pll_ref,
	input wire logic             div_clk,
	input wire logic             osc_running,
	input wire logic             configured,
	input wire logic [IDX_W-1:0] mclk_idx,
	input wire logic [KHZ_W-1:0] mclk_khz
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	run_on_a: assert property (cfg_osc_en && user_osc_en |=> osc_running)
		else $error("oscillator did not start");
	run_off_a: assert property (!(cfg_osc_en && user_osc_en) |=> !osc_running && !osc_out)
		else $error("oscillator did not stop");
	gclk_path_a: assert property (gclk_src |-> $past(osc_out) && !$past(route_to_pll))
		else $error("global clock source wrong");
	pll_path_a: assert property (pll_ref |-> $past(osc_out) && $past(route_to_pll))
		else $error("pll reference wrong");
	div_idle_a: assert property (!osc_running [*3] |-> !div_clk)
		else $error("divider runs while stopped");
	mclk_dflt_a: assert property (!configured |-> mclk_idx == DEFAULT_IDX && mclk_khz == DEFAULT_KHZ)
		else $error("default frequency lost");
	bits_apply_a: assert property (!configured && cfg_clk_bits_rcvd |=> configured)
		else $error("clock bits not applied");
	idx_hold_a: assert property (configured && $past(configured) |-> $stable(mclk_idx))
		else $error("index changed while configured");
	idx_range_a: assert property (mclk_idx <= LAST_IDX)
		else $error("index out of range");
	top_khz_a: assert property (mclk_idx == LAST_IDX |-> mclk_khz == 18'h2_0788)
		else $error("top frequency wrong");
endmodule : oscsel_top_chk
bind oscsel_top oscsel_top_chk u_oscsel_top_chk (.core_clk, .rst, .cfg_osc_en, .user_osc_en,
	.cfg_clk_bits_rcvd, .route_to_pll, .osc_out, .gclk_src, .pll_ref, .div_clk, .osc_running,
	.configured, .mclk_idx, .mclk_khz);

/* oscsel_clk_tree.sv */
`timescale 1ns/1ps
// ****************************************************************
// Clock tree and pll reference: counts rising edges
// ****************************************************************
module oscsel_clk_tree
(
	input  wire logic        core_clk,
	input  wire logic        clr,
	input  wire logic        gclk_src,
	input  wire logic        pll_ref,
	input  wire logic        div_clk,
	output logic      [15:0] n_gclk,
	output logic      [15:0] n_pll,
	output logic      [15:0] n_div
);
	logic [2:0] prev_r;
	always_ff @(posedge core_clk)
	begin
		prev_r <= {gclk_src, pll_ref, div_clk};
		n_gclk <= clr ? 16'h0000 : n_gclk + 16'(gclk_src & ~prev_r[2]);
		n_pll  <= clr ? 16'h0000 : n_pll + 16'(pll_ref & ~prev_r[1]);
		n_div  <= clr ? 16'h0000 : n_div + 16'(div_clk & ~prev_r[0]);
	end
endmodule : oscsel_clk_tree

/* tb_oscsel_top.sv */
`timescale 1ns/1ps
`define CHK(n,e,a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
// ****************************************************************
// Testbench
// ****************************************************************
module tb_oscsel_top;
	import oscsel_pkg::*;
	logic core_clk, rst, cfg_osc_en, user_osc_en, cfg_freq_wr, cfg_clk_bits_rcvd;
	logic cfg_restart, route_to_pll, clr, osc_out, gclk_src, pll_ref, div_clk, osc_running, configured;
	logic [IDX_W-1:0] cfg_freq_sel, mclk_idx;
	logic [KHZ_W-1:0] mclk_khz;
	logic [DIV_W-1:0] div_ratio;
	logic [15:0]      n_gclk, n_pll, n_div;
	int               error_cnt, checks_done, cyc_cnt;
	oscsel_top u_oscsel_top (.core_clk(core_clk), .rst(rst), .cfg_osc_en(cfg_osc_en),
		.user_osc_en(user_osc_en), .cfg_freq_wr(cfg_freq_wr), .cfg_freq_sel(cfg_freq_sel),
		.cfg_clk_bits_rcvd(cfg_clk_bits_rcvd), .cfg_restart(cfg_restart), .route_to_pll(route_to_pll),
		.div_ratio(div_ratio), .osc_out(osc_out), .gclk_src(gclk_src), .pll_ref(pll_ref),
		.div_clk(div_clk), .osc_running(osc_running), .configured(configured),
		.mclk_idx(mclk_idx), .mclk_khz(mclk_khz));
	oscsel_clk_tree u_oscsel_clk_tree (.core_clk(core_clk), .clr(clr), .gclk_src(gclk_src),
		.pll_ref(pll_ref), .div_clk(div_clk), .n_gclk(n_gclk), .n_pll(n_pll), .n_div(n_div));
	task close_out;
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// Clear edge counts, then let 400 cycles pass
	task window;
		@(posedge core_clk) clr <= 1'b1;
		@(posedge core_clk) clr <= 1'b0;
		repeat (400) @(posedge core_clk);
		#1;
	endtask : window
	task t_route;
		@(posedge core_clk) {cfg_osc_en, user_osc_en, div_ratio} <= {2'b11, 8'h01};
		window();
		`CHK("gclk", 1'b1, n_gclk >= 19 && n_gclk <= 23)
		`CHK("div", 1'b1, n_div >= 4 && n_div <= 6)
		@(posedge core_clk) route_to_pll <= 1'b1;
		window();
		`CHK("pll", 1'b1, n_pll >= 19 && n_pll <= 23)
		`CHK("gclk off", 16'h0000, n_gclk)
		@(posedge core_clk) user_osc_en <= 1'b0;
		window();
		`CHK("stopped", 16'h0000, n_pll)
		`CHK("div stopped", 16'h0000, n_div)
		`CHK("running", 1'b0, osc_running)
		$display("route test ended");
	endtask : t_route
	task t_nosel;
		`CHK("reset khz", DEFAULT_KHZ, mclk_khz)
		@(posedge core_clk) cfg_restart <= 1'b1;
		@(posedge core_clk) {cfg_restart, cfg_clk_bits_rcvd} <= 2'b01;
		#1;
		`CHK("restart idle", 1'b0, configured)
		@(posedge core_clk) cfg_clk_bits_rcvd <= 1'b0;
		#1;
		`CHK("conf", 1'b1, configured)
		`CHK("idx", DEFAULT_IDX, mclk_idx)
		`CHK("khz", DEFAULT_KHZ, mclk_khz)
		$display("no selection test ended");
	endtask : t_nosel
	// Restart, write two codes, apply, compare
	task t_sel(input logic [4:0] a, input logic [4:0] b, input logic [4:0] e, input logic [17:0] k);
		@(posedge core_clk) cfg_restart <= 1'b1;
		@(posedge core_clk) {cfg_restart, cfg_freq_wr, cfg_freq_sel} <= {2'b01, a};
		@(posedge core_clk) cfg_freq_sel <= b;
		@(posedge core_clk) {cfg_freq_wr, cfg_clk_bits_rcvd} <= 2'b01;
		#1;
		`CHK("early idx", DEFAULT_IDX, mclk_idx)
		@(posedge core_clk) cfg_clk_bits_rcvd <= 1'b0;
		#1;
		`CHK("idx", e, mclk_idx)
		`CHK("khz", k, mclk_khz)
		$display("selection test ended");
	endtask : t_sel
	// Reset while configured, with the oscillator stopped, returns to the default index
	task t_reset;
		@(posedge core_clk) rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		`CHK("rst idx", DEFAULT_IDX, mclk_idx)
		`CHK("rst khz", DEFAULT_KHZ, mclk_khz)
		`CHK("rst conf", 1'b0, configured)
		$display("reset test ended");
	endtask : t_reset
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == 3000)
		begin
			error_cnt++;
			close_out();
		end
	end
	initial
	begin
		{rst, cfg_osc_en, user_osc_en, cfg_freq_wr, cfg_clk_bits_rcvd} = 5'b10000;
		{cfg_restart, route_to_pll, clr, cfg_freq_sel, div_ratio} = 16'h0000;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_route();
		t_nosel();
		t_sel(5'h05, 5'h13, 5'h13, 18'h1_5A5E);
		t_sel(5'h14, 5'h15, 5'h14, 18'h2_0788);
		t_reset();
		close_out();
	end
endmodule : tb_oscsel_top
